// *** hdl/irq_ctrl_map.svh ***
// Register indices, field positions and reset values of the interrupt block.
// Assumes inclusion from any file that needs them; definitions only.
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH

// Register indices; byte address on the bus is four times the index
`define IDX_ENABLE_PRIMARY    8'ha8
`define IDX_LEVEL_PRIMARY     8'hb8
`define IDX_REQUEST_FLAGS     8'hc0
`define IDX_ENABLE_PORT       8'he8
`define IDX_PORT_POLARITY     8'he9
`define IDX_LEVEL_PORT        8'hf8

// Field positions
`define BIT_ALL_REQUEST_GATE  7
`define LEVEL_PRIMARY_USED    8'h7f
`define ENABLE_PRIMARY_USED   8'h8f

// Reset values
`define RST_REG8              8'h00

// Vector layout
`define VEC_BASE_STD          16'h0003
`define VEC_BASE_PORT         16'h001b
`define VEC_LAST              16'h0073
`define NUM_SOURCES           12

`endif

// *** hdl/irq_ctrl_pkg.sv ***
// Types shared by the interrupt controller files.
// Assumes irq_ctrl_map.svh is compiled alongside.
package irq_ctrl_pkg;

    // Service nesting; Gray along idle, low, low+high, high
    typedef enum logic [1:0] {
        SVC_IDLE = 2'b00,
        SVC_LOW  = 2'b01,
        SVC_NEST = 2'b11,
        SVC_HIGH = 2'b10
    } svc_e;

    typedef struct packed {
        logic [7:0]  enable_primary_q;
        logic [7:0]  level_primary_q;
        logic [7:0]  enable_port_q;
        logic [7:0]  polarity_q;
        logic [7:0]  level_port_q;
        logic [7:0]  flag_q;
        logic [1:0]  tmr_pend_q;
        svc_e        svc_q;
        logic [3:0]  src_q;
        logic        irq_req_q;
        logic [15:0] vec_q;
        logic        high_q;
        logic        wake_q;
        logic        wr_pend_q;
        logic [7:0]  wr_idx_q;
        logic [31:0] hrdata_q;
        logic        hreadyout_q;
        logic        hresp_q;
    } state_s;

endpackage

// *** hdl/level_sync.sv ***
// Three-stage synchroniser bank with agreement filter for pin inputs.
// Assumes asynchronous inputs and the system clock and reset.
`timescale 1ns/1ns
module level_sync #(
    parameter int WIDTH = 10
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic out_q;
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    s1_q  <= 1'b1;
                    s2_q  <= 1'b1;
                    s3_q  <= 1'b1;
                    out_q <= 1'b1;
                end
                else
                begin
                    s1_q <= pin_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // A change counts once stages two and three agree
                    if (s2_q == s3_q)
                        out_q <= s3_q;
                end
            end
            assign level_out[i] = out_q;
        end
    endgenerate

endmodule

// *** hdl/irq_ctrl.sv ***
// Twelve-source, two-level vectored interrupt controller with AHB-Lite
// register access. Assumes a core that pulses irq_ack when it takes the
// presented vector and irq_return when a service routine ends.
// What this block does
// - Twelve sources, each with its own vector
// - Per-source enable; blocked source gives no vector
// - Global gate bit 7 blocks every source
// - Primary enable bits: timer1, line1, timer0, line0
// - Port enable register holds lines nine to two
// - Per-source level bit; primary register layout
// - Primary level bit 7 unused; 6:4 stored
// - Port level register holds lines nine to two
// - Port lines recognised by level, not edge
// - Enabled port request wakes from power down
// - Polarity bit: zero low, one high
// - Port flag set by hardware, cleared by software
// - Flag still set re-raises the interrupt
// - Port flags read and written in one register
// - Fixed order among equal levels; vectors 03-73
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "irq_ctrl_map.svh"
module irq_ctrl
    import irq_ctrl_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_line_zero,
    input  wire logic        ext_line_one,
    input  wire logic        timer_zero_overflow,
    input  wire logic        timer_one_overflow,
    input  wire logic [7:0]  port_line_input,
    input  wire logic        power_down,
    input  wire logic        irq_ack,
    input  wire logic        irq_return,
    output logic             irq_req,
    output logic      [15:0] irq_vector,
    output logic             irq_high,
    output logic             wake_up
);

    state_s q;
    state_s d;

    logic [9:0]  pins_sync;
    logic [7:0]  line_active;
    logic [11:0] en_vec;
    logic [11:0] lvl_vec;
    logic [11:0] pend_vec;
    logic [11:0] elig_hi;
    logic [11:0] elig_lo;
    logic        hi_busy;
    logic        found;
    logic        found_hi;
    logic [3:0]  win;
    logic        addr_ok;
    logic        wr_flag;

    level_sync #(
        .WIDTH (10)
    ) u_sync (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pin_in    ({port_line_input, ext_line_one, ext_line_zero}),
        .level_out (pins_sync)
    );

    // Fixed order among requests of one level
    function automatic logic [3:0] src_at(input int k);
        case (k)
            0:       src_at = 4'h0;
            1:       src_at = 4'h7;
            2:       src_at = 4'h1;
            3:       src_at = 4'h8;
            4:       src_at = 4'h2;
            5:       src_at = 4'h4;
            6:       src_at = 4'h9;
            7:       src_at = 4'h3;
            8:       src_at = 4'h5;
            9:       src_at = 4'ha;
            10:      src_at = 4'h6;
            default: src_at = 4'hb;
        endcase
    endfunction

    // Standard sources step by eight from 03, port lines from 3b
    function automatic logic [15:0] vec_of(input logic [3:0] s);
        if (s < 4'h4)
            vec_of = `VEC_BASE_STD + {9'h000, s, 3'h0};
        else
            vec_of = `VEC_BASE_PORT + {9'h000, s, 3'h0};
    endfunction

    always_comb
    begin
        // Polarity zero selects active low
        line_active = ~(pins_sync[9:2] ^ q.polarity_q);
        en_vec  = {q.enable_port_q, q.enable_primary_q[3:0]};
        lvl_vec = {q.level_port_q, q.level_primary_q[3:0]};
        // Standard lines active low by level; timers latched; port flags
        pend_vec = {q.flag_q, q.tmr_pend_q[1], ~pins_sync[1],
                    q.tmr_pend_q[0], ~pins_sync[0]};
        hi_busy = (q.svc_q == SVC_HIGH) || (q.svc_q == SVC_NEST);
        elig_hi = '0;
        elig_lo = '0;
        if (q.enable_primary_q[`BIT_ALL_REQUEST_GATE])
        begin
            if (!hi_busy)
                elig_hi = pend_vec & en_vec & lvl_vec;
            if (q.svc_q == SVC_IDLE)
                elig_lo = pend_vec & en_vec & ~lvl_vec;
        end
        found    = 1'b0;
        found_hi = 1'b0;
        win      = 4'h0;
        for (int k = 0; k < `NUM_SOURCES; k++)
        begin
            if (!found && elig_hi[src_at(k)])
            begin
                found    = 1'b1;
                found_hi = 1'b1;
                win      = src_at(k);
            end
        end
        for (int k = 0; k < `NUM_SOURCES; k++)
        begin
            if (!found && elig_lo[src_at(k)])
            begin
                found = 1'b1;
                win   = src_at(k);
            end
        end
        addr_ok = hsel && hready && htrans[1] && (haddr[31:10] == 22'h0);
        wr_flag = q.wr_pend_q && (q.wr_idx_q == `IDX_REQUEST_FLAGS);
    end

    always_comb
    begin
        d = q;
        d.hreadyout_q = 1'b1;
        d.hresp_q     = 1'b0;

        // Data phase of a write
        if (q.wr_pend_q)
        begin
            case (q.wr_idx_q)
                `IDX_ENABLE_PRIMARY:
                    d.enable_primary_q = hwdata[7:0]
                                       & `ENABLE_PRIMARY_USED;
                `IDX_LEVEL_PRIMARY:
                    d.level_primary_q = hwdata[7:0]
                                      & `LEVEL_PRIMARY_USED;
                `IDX_ENABLE_PORT:
                    d.enable_port_q = hwdata[7:0];
                `IDX_PORT_POLARITY:
                    d.polarity_q = hwdata[7:0];
                `IDX_LEVEL_PORT:
                    d.level_port_q = hwdata[7:0];
                default:
                    d.enable_primary_q = d.enable_primary_q;
            endcase
        end
        // Software write clears; a recognised request sets and wins
        if (wr_flag)
            d.flag_q = hwdata[7:0];
        d.flag_q = d.flag_q | line_active;

        // Timer overflow latches, cleared when its vector is taken
        if (irq_ack && (q.src_q == 4'h1))
            d.tmr_pend_q[0] = 1'b0;
        if (irq_ack && (q.src_q == 4'h3))
            d.tmr_pend_q[1] = 1'b0;
        d.tmr_pend_q = d.tmr_pend_q
                     | {timer_one_overflow, timer_zero_overflow};

        // Nesting of service routines
        if (irq_ack)
        begin
            unique case (q.svc_q)
                SVC_IDLE: d.svc_q = q.high_q ? SVC_HIGH : SVC_LOW;
                SVC_LOW:  d.svc_q = q.high_q ? SVC_NEST : SVC_LOW;
                SVC_NEST: d.svc_q = SVC_NEST;
                SVC_HIGH: d.svc_q = SVC_HIGH;
            endcase
        end
        else if (irq_return)
        begin
            unique case (q.svc_q)
                SVC_IDLE: d.svc_q = SVC_IDLE;
                SVC_LOW:  d.svc_q = SVC_IDLE;
                SVC_NEST: d.svc_q = SVC_LOW;
                SVC_HIGH: d.svc_q = SVC_IDLE;
            endcase
        end

        // Presented request; dropped while the core acts on the last one
        d.irq_req_q = found && !irq_ack && !irq_return;
        if (found)
        begin
            d.src_q  = win;
            d.vec_q  = vec_of(win);
            d.high_q = found_hi;
        end

        // Wake while powered down on any enabled port-line request
        d.wake_q = power_down
                 && ((line_active | q.flag_q) & q.enable_port_q) != 8'h00;

        // Address phase; read data from the updated register image
        d.wr_pend_q = addr_ok && hwrite && (haddr[1:0] == 2'h0);
        d.wr_idx_q  = haddr[9:2];
        d.hrdata_q  = 32'h0000_0000;
        if (addr_ok && !hwrite && (haddr[1:0] == 2'h0))
        begin
            case (haddr[9:2])
                `IDX_ENABLE_PRIMARY: d.hrdata_q[7:0] = d.enable_primary_q;
                `IDX_LEVEL_PRIMARY:  d.hrdata_q[7:0] = d.level_primary_q;
                `IDX_REQUEST_FLAGS:  d.hrdata_q[7:0] = d.flag_q;
                `IDX_ENABLE_PORT:    d.hrdata_q[7:0] = d.enable_port_q;
                `IDX_PORT_POLARITY:  d.hrdata_q[7:0] = d.polarity_q;
                `IDX_LEVEL_PORT:     d.hrdata_q[7:0] = d.level_port_q;
                default:             d.hrdata_q      = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q.enable_primary_q <= `RST_REG8;
            q.level_primary_q  <= `RST_REG8;
            q.enable_port_q    <= `RST_REG8;
            q.polarity_q       <= `RST_REG8;
            q.level_port_q     <= `RST_REG8;
            q.flag_q      <= `RST_REG8;
            q.tmr_pend_q  <= 2'h0;
            q.svc_q       <= SVC_IDLE;
            q.src_q       <= 4'h0;
            q.irq_req_q   <= 1'b0;
            q.vec_q       <= 16'h0000;
            q.high_q      <= 1'b0;
            q.wake_q      <= 1'b0;
            q.wr_pend_q   <= 1'b0;
            q.wr_idx_q    <= 8'h00;
            q.hrdata_q    <= 32'h0000_0000;
            q.hreadyout_q <= 1'b0;
            q.hresp_q     <= 1'b0;
        end
        else
            q <= d;
    end

    assign hrdata     = q.hrdata_q;
    assign hreadyout  = q.hreadyout_q;
    assign hresp      = q.hresp_q;
    assign irq_req    = q.irq_req_q;
    assign irq_vector = q.vec_q;
    assign irq_high   = q.high_q;
    assign wake_up    = q.wake_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_gate_blocks_all: assert property (
        !q.enable_primary_q[`BIT_ALL_REQUEST_GATE] |=> !q.irq_req_q)
        else $error("request presented with global gate off");

    a_blocked_sources: assert property (
        (en_vec == 12'h000) |=> !q.irq_req_q)
        else $error("request presented with all sources blocked");

    a_vector_range: assert property (
        q.irq_req_q |-> (q.vec_q[2:0] == 3'h3) && (q.vec_q <= `VEC_LAST))
        else $error("vector outside the table");

    a_order_first: assert property (
        (elig_lo[0] && (elig_hi == 12'h000) && !irq_ack && !irq_return)
        |=> q.irq_req_q && (q.vec_q == `VEC_BASE_STD))
        else $error("line zero not chosen first");

    a_flag_sticky: assert property (
        !wr_flag |=> ((q.flag_q & $past(q.flag_q)) == $past(q.flag_q)))
        else $error("port flag cleared without software");

    a_flag_on_level: assert property (
        1'b1 |=> ((q.flag_q & $past(line_active)) == $past(line_active)))
        else $error("active port line did not set its flag");

    a_wake_request: assert property (
        (power_down && ((line_active & q.enable_port_q) != 8'h00))
        |=> q.wake_q)
        else $error("no wake on enabled port request");

    a_high_blocks: assert property (
        (hi_busy && !irq_ack && !irq_return) |=> !q.irq_req_q)
        else $error("request presented during high-level service");

    a_preempt_low: assert property (
        ((q.svc_q == SVC_LOW) && (elig_hi != 12'h000) && !irq_ack
         && !irq_return) |=> q.irq_req_q && q.high_q)
        else $error("high request failed to preempt");

    a_reraise_flag: assert property (
        ((q.svc_q == SVC_IDLE) && q.enable_primary_q[`BIT_ALL_REQUEST_GATE]
         && ((q.flag_q & q.enable_port_q) != 8'h00)
         && !irq_ack && !irq_return)
        |=> q.irq_req_q)
        else $error("pending port flag not raised");

    a_reserved_read: assert property (
        (addr_ok && !hwrite && (haddr[9:0] == {`IDX_LEVEL_PRIMARY, 2'h0}))
        |=> (q.hrdata_q[31:7] == 25'h0))
        else $error("unused primary level bits read nonzero");

    a_timer_latch: assert property (
        timer_zero_overflow |=> q.tmr_pend_q[0])
        else $error("timer zero overflow not latched");

    a_flag_write: assert property (
        wr_flag |=> ((q.flag_q & $past(hwdata[7:0])) == $past(hwdata[7:0])))
        else $error("written port flag not stored");

    a_return_idle: assert property (
        (irq_return && !irq_ack && (q.svc_q == SVC_LOW))
        |=> (q.svc_q == SVC_IDLE))
        else $error("low service did not end on return");

    c_high_taken: cover property (q.irq_req_q && q.high_q ##1 irq_ack);
    c_nesting:    cover property (q.svc_q == SVC_NEST);
    c_wake:       cover property (q.wake_q);
    c_reraise:    cover property (irq_return && (q.flag_q != 8'h00)
                                  ##2 q.irq_req_q);

endmodule

// *** sim/core_model.sv ***
// Core-side model: takes presented vectors and ends service routines.
// Assumes the controller's request, vector and level outputs.
`timescale 1ns/1ns
module core_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        irq_req,
    input  wire logic [15:0] irq_vector,
    input  wire logic        irq_high,
    input  wire logic [2:0]  dly,
    input  wire logic        ret_go,
    output logic             irq_ack,
    output logic             irq_return,
    output logic      [15:0] last_vec,
    output logic             last_high,
    output logic      [7:0]  acks
);
    logic [2:0] wait_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
            last_vec <= 16'h0000;
            last_high <= 1'b0;
            acks <= 8'h00;
            wait_q <= 3'h0;
        end
        else
        begin
            irq_ack <= 1'b0;
            // Return only on command, flags may still be set
            irq_return <= ret_go;
            if (irq_ack)
            begin
                // Vector and level as applied by the controller at the ack
                last_vec <= irq_vector;
                last_high <= irq_high;
                acks <= acks + 8'h01;
            end
            if (irq_req !== 1'b1 || irq_ack)
                wait_q <= 3'h0;
            else if (wait_q < dly)
                wait_q <= wait_q + 3'h1;
            else
            begin
                irq_ack <= 1'b1;
                wait_q <= 3'h0;
            end
        end
    end
endmodule

// *** sim/twelve_source_two_level_interrupt_ctrl_bench.sv ***
// Self-checking bench for the interrupt controller.
// Assumes irq_ctrl, level_sync and core_model are compiled before it.
`timescale 1ns/1ns
`include "irq_ctrl_map.svh"
module twelve_source_two_level_interrupt_ctrl_bench;
    import irq_ctrl_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, dly = 3'h0;
    logic        hready, hreadyout, hresp, irq_req, irq_high, wake_up;
    logic        ext_line_zero = 1'b1, ext_line_one = 1'b1;
    logic        timer_zero_overflow = 1'b0, timer_one_overflow = 1'b0;
    logic [7:0]  port_line_input = 8'hff, acks, n, fl;
    logic        power_down = 1'b0, ret_go = 1'b0, irq_ack, irq_return;
    logic [15:0] irq_vector, last_vec;
    logic        last_high;
    int          errors = 0, tests_run = 0, cycles = 0;
    localparam logic [7:0] regs [6] = '{`IDX_ENABLE_PRIMARY,
        `IDX_LEVEL_PRIMARY, `IDX_REQUEST_FLAGS, `IDX_ENABLE_PORT,
        `IDX_LEVEL_PORT, `IDX_PORT_POLARITY};
    localparam logic [15:0] order_tab [12] = '{16'h0003, 16'h0053,
        16'h000b, 16'h005b, 16'h0013, 16'h003b, 16'h0063, 16'h001b,
        16'h0043, 16'h006b, 16'h004b, 16'h0073};

    assign hready = hreadyout;

    irq_ctrl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .ext_line_zero, .ext_line_one, .timer_zero_overflow,
        .timer_one_overflow, .port_line_input, .power_down, .irq_ack,
        .irq_return, .irq_req, .irq_vector, .irq_high, .wake_up);

    core_model core_u (.hclk, .hresetn, .irq_req, .irq_vector, .irq_high,
        .dly, .ret_go, .irq_ack, .irq_return, .last_vec, .last_high, .acks);

    initial
    begin
        forever #2 hclk = ~hclk;
    end

    task automatic give_verdict();
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [7:0] reg_mask(input logic [7:0] idx);
        if (idx == `IDX_ENABLE_PRIMARY)
            return 8'h8f;
        if (idx == `IDX_LEVEL_PRIMARY)
            return 8'h7f;
        return 8'hff;
    endfunction

    task automatic wait_rdy();
        do @(posedge hclk); while (hready !== 1'b1);
    endtask

    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd);
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] t;
        bus(1'b1, idx, d, t);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] t;
        bus(1'b0, idx, 8'h00, t);
        chk("register", t, {24'h0, exp});
        chk("okay", {31'h0, hresp}, 32'h0);
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    task automatic wait_ack(input logic [7:0] prev);
        int k;
        k = 0;
        while (acks === prev && k < 60)
        begin
            @(posedge hclk);
            k++;
        end
        chk("ack", {31'h0, acks !== prev}, 32'h1);
    endtask

    task automatic quiet(input int c);
        logic bad;
        bad = 1'b0;
        repeat (c)
        begin
            @(posedge hclk);
            if (irq_req !== 1'b0)
                bad = 1'b1;
        end
        chk("quiet", {31'h0, bad}, 32'h0);
    endtask

    task automatic ret();
        ret_go <= 1'b1;
        @(posedge hclk);
        ret_go <= 1'b0;
    endtask

    task automatic tpulse();
        timer_zero_overflow <= 1'b1;
        timer_one_overflow <= 1'b1;
        @(posedge hclk);
        timer_zero_overflow <= 1'b0;
        timer_one_overflow <= 1'b0;
    endtask

    initial
    begin
        logic [7:0] d;
        logic [15:0] v;
        void'($urandom(32'h88f75540));
        do_reset();
        foreach (regs[i]) rdc(regs[i], 8'h00);
        foreach (regs[i])
        begin
            d = 8'($urandom);
            wr(regs[i], d);
            rdc(regs[i], d & reg_mask(regs[i]));
        end
        wr(8'h10, 8'h5a);
        rdc(8'h10, 8'h00);
        do_reset();
        // Gate and individual enable
        wr(`IDX_REQUEST_FLAGS, 8'h08);
        wr(`IDX_ENABLE_PORT, 8'h08);
        wr(`IDX_ENABLE_PRIMARY, 8'h0f);
        quiet(20);
        wr(`IDX_ENABLE_PORT, 8'h00);
        wr(`IDX_ENABLE_PRIMARY, 8'h80);
        quiet(20);
        n = acks;
        wr(`IDX_ENABLE_PORT, 8'h08);
        wait_ack(n);
        chk("vector", last_vec, 16'h0053);
        n = acks;
        ret();
        wait_ack(n);
        chk("reraise", last_vec, 16'h0053);
        wr(`IDX_REQUEST_FLAGS, 8'h00);
        ret();
        quiet(20);
        // All twelve pending at one level
        wr(`IDX_ENABLE_PRIMARY, 8'h0f);
        wr(`IDX_ENABLE_PORT, 8'hff);
        fl = 8'hff;
        wr(`IDX_REQUEST_FLAGS, fl);
        ext_line_zero <= 1'b0;
        ext_line_one <= 1'b0;
        tpulse();
        repeat (8) @(posedge hclk);
        n = acks;
        wr(`IDX_ENABLE_PRIMARY, 8'h8f);
        for (int i = 0; i < 12; i++)
        begin
            wait_ack(n);
            chk("order", last_vec, order_tab[i]);
            n = acks;
            v = last_vec;
            if (v == 16'h0003)
                ext_line_zero <= 1'b1;
            if (v == 16'h0013)
                ext_line_one <= 1'b1;
            if (v >= 16'h003b)
                fl[(v - 16'h003b) >> 3] = 1'b0;
            wr(`IDX_REQUEST_FLAGS, fl);
            dly <= 3'($urandom_range(0, 4));
            repeat (8) @(posedge hclk);
            ret();
        end
        // Polarity, level recognition and wake
        wr(`IDX_ENABLE_PRIMARY, 8'h00);
        port_line_input <= 8'hfe;
        repeat (8) @(posedge hclk);
        wr(`IDX_PORT_POLARITY, 8'h01);
        repeat (8) @(posedge hclk);
        wr(`IDX_REQUEST_FLAGS, 8'h00);
        repeat (8) @(posedge hclk);
        rdc(`IDX_REQUEST_FLAGS, 8'h00);
        port_line_input <= 8'hff;
        repeat (8) @(posedge hclk);
        rdc(`IDX_REQUEST_FLAGS, 8'h01);
        wr(`IDX_REQUEST_FLAGS, 8'h00);
        repeat (2) @(posedge hclk);
        rdc(`IDX_REQUEST_FLAGS, 8'h01);
        power_down <= 1'b1;
        wr(`IDX_ENABLE_PORT, 8'h00);
        repeat (4) @(posedge hclk);
        chk("wake", {31'h0, wake_up}, 32'h0);
        wr(`IDX_ENABLE_PORT, 8'h01);
        repeat (4) @(posedge hclk);
        chk("wake", {31'h0, wake_up}, 32'h1);
        power_down <= 1'b0;
        do_reset();
        // Preemption by the higher level
        wr(`IDX_ENABLE_PORT, 8'h81);
        wr(`IDX_LEVEL_PORT, 8'h80);
        wr(`IDX_REQUEST_FLAGS, 8'h01);
        n = acks;
        wr(`IDX_ENABLE_PRIMARY, 8'h82);
        wait_ack(n);
        chk("low", {last_high, last_vec}, 17'h0003b);
        n = acks;
        tpulse();
        quiet(10);
        wr(`IDX_REQUEST_FLAGS, 8'h81);
        wait_ack(n);
        chk("high", {last_high, last_vec}, 17'h10073);
        wr(`IDX_REQUEST_FLAGS, 8'h00);
        n = acks;
        ret();
        quiet(10);
        ret();
        wait_ack(n);
        chk("timer", {last_high, last_vec}, 17'h0000b);
        ret();
        give_verdict();
    end
endmodule
